// ---- pkg/acc_pkg.sv ----
// Package: register map, field layout, reset values and types of the converter control block
package acc_pkg;

	// ****************************************
	// Register pointer codes
	// ****************************************
	localparam logic [1:0]  PTR_CONVERSION = 2'h0;
	localparam logic [1:0]  PTR_CONFIG     = 2'h1;
	localparam logic [1:0]  PTR_LO_THRESH  = 2'h2;
	localparam logic [1:0]  PTR_HI_THRESH  = 2'h3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_CONFIG     = 16'h8583;
	localparam logic [15:0] RST_CONVERSION = 16'h0000;
	localparam logic [15:0] RST_LO_THRESH  = 16'h8000;
	localparam logic [15:0] RST_HI_THRESH  = 16'h7FFF;

	// ****************************************
	// Field codes
	// ****************************************
	localparam logic [1:0]  QUEUE_DISABLE  = 2'h3;
	localparam logic [1:0]  QUEUE_ONE      = 2'h0;
	localparam logic [1:0]  QUEUE_TWO      = 2'h1;
	localparam int unsigned DATA_LSB       = 4;
	localparam int unsigned CLK_HZ         = 100_000_000;

	// Configuration word, msb first: 15 | 14:12 | 11:9 | 8 | 7:5 | 4 | 3 | 2 | 1:0
	typedef struct packed {
		logic       conv_status_start;
		logic [2:0] input_select;
		logic [2:0] gain_range;
		logic       single_shot;
		logic [2:0] sample_rate_sel;
		logic       window_mode;
		logic       alert_polarity;
		logic       alert_latch;
		logic [1:0] alert_queue;
	} acc_cfg_s;

	// Host-side register access: pointer load plus read/write strobes
	typedef struct packed {
		logic        ptr_wr;
		logic [1:0]  ptr;
		logic        wr;
		logic        rd;
		logic [15:0] wdata;
	} acc_req_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} acc_state_e;

endpackage

// ---- rtl/acc_adc_config_and_comparator.sv ----
// Configuration register, conversion sequencing and threshold comparator of a small converter
`timescale 1ns/1ps
module acc_adc_config_and_comparator #(
	parameter int unsigned       CLK_HZ   = acc_pkg::CLK_HZ,
	parameter logic [6:0]        DEV_ADDR = 7'h48  // Arbitrary value
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	// Register access from the serial interface
	input  wire acc_pkg::acc_req_s req_i,
	output logic [15:0]            reg_rdata_o,
	// Alert response from the serial interface
	input  wire logic              alert_resp_i,
	output logic                   alert_resp_valid_o,
	output logic [6:0]             alert_resp_addr_o,
	// Analog front end
	input  wire logic [11:0]       sample_i,
	output logic [2:0]             input_select_o,
	output logic [2:0]             gain_range_o,
	output logic                   converting_o,
	// Alert/ready pin
	output logic                   alert_o,
	output logic                   alert_oe_n_o
);

	// ****************************************
	// Registers
	// ****************************************
	acc_pkg::acc_cfg_s  cfg_reg;
	acc_pkg::acc_state_e state_reg;
	logic [1:0]         ptr_reg;
	logic [15:0]        conv_reg;
	logic [15:0]        lo_reg;
	logic [15:0]        hi_reg;
	logic [31:0]        timer_reg;
	logic [2:0]         exceed_cnt_reg;
	logic               cmp_act_reg;
	logic               rdy_pulse_reg;

	// Conversion time in clocks for a sample rate code.
	// Integer division: a rate that does not divide CLK_HZ
	// runs a little fast, which the timing model accepts.
	function automatic logic [31:0] period(input logic [2:0] sel);
		int unsigned rate;
		unique case (sel)
			3'h0: rate = 128;
			3'h1: rate = 250;
			3'h2: rate = 490;
			3'h3: rate = 920;
			3'h4: rate = 1600;
			3'h5: rate = 2400;
			default: rate = 3300;
		endcase
		period = 32'(CLK_HZ / rate);
	endfunction

	// ****************************************
	// Decode
	// ****************************************
	acc_pkg::acc_cfg_s wcfg;
	wire               wr_cfg   = req_i.wr && (ptr_reg == acc_pkg::PTR_CONFIG);
	wire               busy     = (state_reg == acc_pkg::ST_CONV);
	wire               done     = busy && (timer_reg <= 32'h1);
	wire               start_ss = wr_cfg && !busy && wcfg.conv_status_start
	                              && wcfg.single_shot;
	wire               start_cont = !cfg_reg.single_shot && (!busy || done);
	wire               start    = start_ss || start_cont;

	// ****************************************
	// Threshold compare
	// ****************************************
	// Only the 12 result bits take part; writes zero the low nibble, but the high threshold reset value 7FFF leaves it at F
	wire signed [11:0] smp      = sample_i;
	wire signed [11:0] lo_v     = lo_reg[15:acc_pkg::DATA_LSB];
	wire signed [11:0] hi_v     = hi_reg[15:acc_pkg::DATA_LSB];
	wire               above    = smp > hi_v;
	wire               below    = smp < lo_v;
	wire               exceed   = above || (cfg_reg.window_mode && below);
	wire               clear_c  = cfg_reg.window_mode ? !(above || below) : below;

	// ****************************************
	// Alert qualification
	// ****************************************
	// Ready mode borrows the threshold sign bits, as the pin has one use
	wire               ready_md = hi_reg[15] && !lo_reg[15];
	wire               q_off    = cfg_reg.alert_queue == acc_pkg::QUEUE_DISABLE;
	wire               read_cv  = req_i.rd && (ptr_reg == acc_pkg::PTR_CONVERSION);
	wire               ack_resp = alert_resp_i && cmp_act_reg && !ready_md;
	wire               unlatch  = read_cv || ack_resp;
	wire [2:0]         q_need   = (cfg_reg.alert_queue == acc_pkg::QUEUE_ONE) ? 3'h1 :
	                              (cfg_reg.alert_queue == acc_pkg::QUEUE_TWO) ? 3'h2 : 3'h4;
	wire [2:0]         cnt_next = exceed ? ((exceed_cnt_reg < q_need) ?
	                              3'(exceed_cnt_reg + 3'h1) : exceed_cnt_reg) : 3'h0;
	wire               fire     = cnt_next >= q_need;
	wire               act_now  = ready_md ? (cfg_reg.single_shot ? busy : rdy_pulse_reg)
	                              : cmp_act_reg;
	assign wcfg = req_i.wdata;

	// ****************************************
	// Pointer and configuration
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ptr_reg <= acc_pkg::PTR_CONVERSION;
			cfg_reg <= acc_pkg::RST_CONFIG;
			lo_reg  <= acc_pkg::RST_LO_THRESH;
			hi_reg  <= acc_pkg::RST_HI_THRESH;
		end else begin
			if (req_i.ptr_wr)
				ptr_reg <= req_i.ptr;
			if (wr_cfg) begin
				cfg_reg                   <= wcfg;
				// Start bit never stored; reads return the live status
				cfg_reg.conv_status_start <= 1'b0;
			end
			// Low nibble forced to zero to match the result format
			if (req_i.wr && ptr_reg == acc_pkg::PTR_LO_THRESH)
				lo_reg <= {req_i.wdata[15:acc_pkg::DATA_LSB], 4'h0};
			if (req_i.wr && ptr_reg == acc_pkg::PTR_HI_THRESH)
				hi_reg <= {req_i.wdata[15:acc_pkg::DATA_LSB], 4'h0};
		end
	end

	// ****************************************
	// Conversion sequencing
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg     <= acc_pkg::ST_IDLE;
			timer_reg     <= 32'h0;
			conv_reg      <= acc_pkg::RST_CONVERSION;
			rdy_pulse_reg <= 1'b0;
		end else begin
			rdy_pulse_reg <= done && !cfg_reg.single_shot;
			if (done)
				conv_reg <= {sample_i, 4'h0};
			// A start in the cycle of a finish restarts with no gap
			if (start) begin
				state_reg <= acc_pkg::ST_CONV;
				timer_reg <= period(start_ss ? wcfg.sample_rate_sel : cfg_reg.sample_rate_sel);
			end else if (done) begin
				state_reg <= acc_pkg::ST_IDLE;
				timer_reg <= 32'h0;
			end else if (busy) begin
				timer_reg <= timer_reg - 32'h1;
			end
		end
	end

	// ****************************************
	// Comparator
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || q_off) begin
			exceed_cnt_reg <= 3'h0;
			cmp_act_reg    <= 1'b0;
		end else begin
			// Queue counter only advances on a finished conversion
			if (done)
				exceed_cnt_reg <= cnt_next;
			// New exceed wins over a clear in the same cycle
			if (done && fire)
				cmp_act_reg <= 1'b1;
			else if (cfg_reg.alert_latch ? unlatch : (done && clear_c))
				cmp_act_reg <= 1'b0;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o        <= 16'h0000;
			alert_resp_valid_o <= 1'b0;
			alert_resp_addr_o  <= 7'h00;
			input_select_o     <= 3'h0;
			gain_range_o       <= 3'h0;
			converting_o       <= 1'b0;
			alert_o            <= 1'b0;
			alert_oe_n_o       <= 1'b1;
		end else begin
			alert_resp_valid_o <= ack_resp;
			alert_resp_addr_o  <= ack_resp ? DEV_ADDR : 7'h00;
			input_select_o     <= cfg_reg.input_select;
			gain_range_o       <= cfg_reg.gain_range;
			converting_o       <= busy;
			// Level always computed; the enable decides if it reaches the pad
			alert_o            <= cfg_reg.alert_polarity ? act_now : !act_now;
			alert_oe_n_o       <= q_off;
			// Read data holds until the next read strobe
			if (req_i.rd) begin
				unique case (ptr_reg)
					acc_pkg::PTR_CONVERSION: reg_rdata_o <= conv_reg;
					acc_pkg::PTR_CONFIG:     reg_rdata_o <= {!busy, cfg_reg[14:0]};
					acc_pkg::PTR_LO_THRESH:  reg_rdata_o <= lo_reg;
					acc_pkg::PTR_HI_THRESH:  reg_rdata_o <= hi_reg;
				endcase
			end
		end
	end

endmodule // acc_adc_config_and_comparator

// ---- verification/acc_ctrl_model.sv ----
// Controller model: pointer loads and register strobes
`timescale 1ns/1ps
module acc_ctrl_model (
	// Clock
	input  wire logic         clk_i,
	// Register port
	input  wire logic [15:0]  rdata_i,
	output acc_pkg::acc_req_s req_o
);
	initial req_o = '0;
	// Pointer first on every access; released lines show inverted values
	task automatic xfer(input logic [1:0] p, input logic w, input logic [15:0] dat);
		@(negedge clk_i);
		req_o = '{1'b1, p, 1'b0, 1'b0, 16'h0000};
		@(negedge clk_i);
		req_o = '{1'b0, ~p, w, ~w, dat};
		@(negedge clk_i);
		req_o = '{1'b0, p, 1'b0, 1'b0, ~dat};
	endtask
	task automatic rd(input logic [1:0] p, output logic [15:0] dat);
		xfer(p, 1'b0, 16'h0000);
		@(negedge clk_i);
		dat = rdata_i;
	endtask
endmodule // acc_ctrl_model

// ---- verification/acc_cfg_asserts.sv ----
// Port assertions of the converter control block
`timescale 1ns/1ps
module acc_cfg_asserts #(
	parameter logic [6:0] DEV_ADDR = 7'h48 // Arbitrary value
) (
	input wire logic              clk_i,
	input wire logic              sys_rst_i,
	input wire acc_pkg::acc_req_s req_i,
	input wire logic [15:0]       reg_rdata_o,
	input wire logic              alert_resp_i,
	input wire logic              alert_resp_valid_o,
	input wire logic [6:0]        alert_resp_addr_o,
	input wire logic [2:0]        input_select_o,
	input wire logic [2:0]        gain_range_o,
	input wire logic              converting_o,
	input wire logic              alert_oe_n_o
);
	logic [1:0]  ptr_reg;
	logic [15:0] cfg_reg;
	wire         cfg_wr = req_i.wr && (ptr_reg == acc_pkg::PTR_CONFIG);
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ptr_reg <= acc_pkg::PTR_CONVERSION;
			cfg_reg <= acc_pkg::RST_CONFIG;
		end else begin
			if (req_i.ptr_wr)
				ptr_reg <= req_i.ptr;
			if (cfg_wr)
				cfg_reg <= req_i.wdata;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	reset_outs_a: assert property ($fell(sys_rst_i) |-> alert_oe_n_o && !converting_o)
		else $error("outputs not idle after reset");
	gain_copy_a: assert property (cfg_wr ##1 !cfg_wr |-> ##1 gain_range_o == cfg_reg[11:9])
		else $error("gain output differs from config");
	input_copy_a: assert property (cfg_wr ##1 !cfg_wr |-> ##1 input_select_o == cfg_reg[14:12])
		else $error("input select differs from config");
	queue_off_a: assert property (!cfg_wr [*2] |-> alert_oe_n_o == (cfg_reg[1:0] == 2'h3))
		else $error("pin drive disagrees with queue field");
	start_conv_a: assert property (cfg_wr && req_i.wdata[15] && req_i.wdata[8] && !converting_o
		|-> ##[1:2] converting_o)
		else $error("start write did not begin conversion");
	zero_start_a: assert property (cfg_wr && !req_i.wdata[15] && req_i.wdata[8] && !converting_o
		|-> ##1 !converting_o ##1 !converting_o)
		else $error("zero start bit began conversion");
	status_read_a: assert property (req_i.rd && ptr_reg == acc_pkg::PTR_CONFIG
		|=> reg_rdata_o[15] == !converting_o)
		else $error("status bit wrong on read");
	resp_addr_a: assert property (alert_resp_valid_o |-> alert_resp_addr_o == DEV_ADDR)
		else $error("wrong response address");
	resp_cause_a: assert property (alert_resp_valid_o |-> $past(alert_resp_i))
		else $error("response without request");
endmodule // acc_cfg_asserts
bind acc_adc_config_and_comparator acc_cfg_asserts #(.DEV_ADDR(DEV_ADDR)) acc_cfg_asserts_inst (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .reg_rdata_o(reg_rdata_o),
	.alert_resp_i(alert_resp_i), .alert_resp_valid_o(alert_resp_valid_o),
	.alert_resp_addr_o(alert_resp_addr_o), .input_select_o(input_select_o),
	.gain_range_o(gain_range_o), .converting_o(converting_o), .alert_oe_n_o(alert_oe_n_o));

// ---- verification/acc_adc_config_and_comparator_bench.sv ----
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module acc_adc_config_and_comparator_bench;
	localparam logic [6:0] DEV = 7'h48; // Arbitrary value
	localparam logic [1:0] PC  = acc_pkg::PTR_CONFIG;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, resp_i = 1'b0, resp_v, conv, alert, oe_n;
	logic [11:0] sample_i = 12'h000, s;
	logic [15:0] rdata, d, w;
	logic [6:0] addr;
	logic [2:0] mux, gain;
	acc_pkg::acc_req_s req;
	integer seed = 80944, n_mismatch = 0, compares = 0;
	initial forever #5 clk_i = ~clk_i;
	acc_adc_config_and_comparator #(.CLK_HZ(100000), .DEV_ADDR(DEV)) acc_adc_config_and_comparator_inst (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .reg_rdata_o(rdata),
		.alert_resp_i(resp_i), .alert_resp_valid_o(resp_v), .alert_resp_addr_o(addr),
		.sample_i(sample_i), .input_select_o(mux), .gain_range_o(gain), .converting_o(conv),
		.alert_o(alert), .alert_oe_n_o(oe_n));
	acc_ctrl_model acc_ctrl_model_inst (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	function automatic logic [15:0] conv_word(input logic [11:0] v);
		return {v, 4'h0};
	endfunction
	task automatic report_and_stop;
		$display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic shot(input logic [11:0] v, input logic [15:0] cw);
		sample_i = v;
		acc_ctrl_model_inst.xfer(PC, 1'b1, cw);
		@(negedge clk_i);
		chk({15'h0, conv}, 16'h0001);
		for (int i = 0; i < 2000 && conv; i++) @(negedge clk_i);
		if (conv) begin
			n_mismatch++;
			$display("MISMATCH at %0t: conversion hangs", $time);
			report_and_stop;
		end
	endtask
	initial begin
		repeat (12) @(negedge clk_i);
		sys_rst_i = 1'b0;
		acc_ctrl_model_inst.rd(PC, d);
		chk(d, acc_pkg::RST_CONFIG);
		for (int k = 0; k < 8; k++) begin
			w = {1'b0, k[2:0], ~k[2:0], 1'b1, 8'hE3};
			acc_ctrl_model_inst.xfer(PC, 1'b1, w);
			@(negedge clk_i);
			chk({9'h0, conv, mux, gain}, {10'h0, w[14:9]});
		end
		$display("field codes done");
		for (int k = 0; k < 4; k++) begin
			s = 12'($random(seed));
			w = {1'b1, 3'($random(seed)), 3'h2, 1'b1, 8'hE3};
			sample_i = s;
			acc_ctrl_model_inst.xfer(PC, 1'b1, w);
			acc_ctrl_model_inst.xfer(PC, 1'b1, w);
			acc_ctrl_model_inst.rd(PC, d);
			chk(d, {1'b0, w[14:0]});
			for (int i = 0; i < 100 && conv; i++) @(negedge clk_i);
			if (conv) begin
				n_mismatch++;
				$display("MISMATCH at %0t: single shot hangs", $time);
				report_and_stop;
			end
			acc_ctrl_model_inst.rd(PC, d);
			chk(d, {1'b1, w[14:0]});
			acc_ctrl_model_inst.rd(acc_pkg::PTR_CONVERSION, d);
			chk(d, conv_word(s));
		end
		$display("single shot done");
		acc_ctrl_model_inst.xfer(acc_pkg::PTR_HI_THRESH, 1'b1, 16'h1000);
		acc_ctrl_model_inst.xfer(acc_pkg::PTR_LO_THRESH, 1'b1, 16'h0800);
		for (int q = 0; q < 3; q++) begin
			w = {1'b1, 6'h02, 1'b1, 6'h3A, q[1:0]};
			shot(12'h050, w);
			for (int n = 1; n <= (1 << q); n++) begin
				shot(12'h200, w);
				chk({14'h0, oe_n, alert}, {15'h0, n == (1 << q)});
			end
		end
		shot(12'h050, w);
		chk({14'h0, oe_n, alert}, 16'h0000);
		w = {1'b1, 6'h02, 1'b1, 8'hE4};
		shot(12'h200, w);
		shot(12'h050, w);
		chk({15'h0, alert}, 16'h0000);
		resp_i = 1'b1;
		@(negedge clk_i);
		resp_i = 1'b0;
		chk({8'h0, resp_v, addr}, {8'h0, 1'b1, DEV});
		@(negedge clk_i);
		chk({15'h0, alert}, 16'h0001);
		acc_ctrl_model_inst.xfer(PC, 1'b1, 16'h05E3);
		@(negedge clk_i);
		chk({15'h0, oe_n}, 16'h0001);
		$display("comparator done");
		report_and_stop;
	end
endmodule // acc_adc_config_and_comparator_bench
